//--- src/psc_pin_cell.sv
`timescale 1ns/1ps
// Per-pin state decode and hold register
module psc_pin_cell
    import psc_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire psc_mode_t mode_i,
    input wire logic reset_pin_low_i,
    input wire logic standby_pin_level_bit_i,
    input wire psc_type_t pin_type_i,
    input wire psc_func_t pin_func_i,
    input wire logic periph_running_i,
    input wire logic periph_out_i,
    input wire logic periph_oe_i,
    input wire logic port_out_i,
    input wire logic port_oe_i,
    input wire logic pad_in_i,
    output logic pad_out_o,
    output logic pad_oe_o,
    output logic pull_up_o,
    output logic core_in_o,
    output logic analog_en_o,
    output logic wake_up_input_o,
    output logic gpio_forced_o,
    output logic config_locked_o
);
    typedef enum logic [2:0] {
        PSC_ST_HIZ_IN,
        PSC_ST_HIZ_LOW,
        PSC_ST_HOLD,
        PSC_ST_GPIO_LOW,
        PSC_ST_NORMAL,
        PSC_ST_GPIO,
        PSC_ST_LOCKED
    } psc_pin_st_t;

    psc_pin_st_t st;
    logic analog;
    logic wake;
    logic pull;
    logic held_out;
    logic held_oe;
    logic standby_pin_level_bit;
    logic ds;

    function automatic logic is_ds(input psc_mode_t m);
        is_ds = (m == PSC_MODE_DS_RTC) || (m == PSC_MODE_DS_STOP);
    endfunction

    function automatic logic is_standby(input psc_mode_t m);
        is_standby = (m == PSC_MODE_TIMER) || (m == PSC_MODE_RTC) || (m == PSC_MODE_STOP);
    endfunction

    assign standby_pin_level_bit = standby_pin_level_bit_i; // [R2]
    assign ds = is_ds(mode_i);

    // Decode is purely combinational so states track mode changes [R19]
    always_comb begin
        st = PSC_ST_NORMAL;
        analog = 1'b0;
        wake = 1'b0;
        pull = 1'b0;
        if (mode_i == PSC_MODE_POR) begin
            // Unstable supply: resources float; GPIO, NMI and analog-output pins unconfigurable [R6]
            st = (pin_func_i == PSC_FUNC_GPIO || pin_func_i == PSC_FUNC_NMI ||
                  pin_func_i == PSC_FUNC_ANALOG_OUT) ? PSC_ST_LOCKED : PSC_ST_HIZ_IN;
            if (pin_func_i == PSC_FUNC_ANALOG_IN) begin
                st = PSC_ST_HIZ_LOW;
            end
        end else if (pin_func_i == PSC_FUNC_ANALOG_IN) begin
            // Checked ahead of the resets: analog input stays live through them
            st = PSC_ST_HIZ_LOW;
            // First analog type loses analog input in and after deep standby [R13]
            analog = !(pin_type_i == PSC_TYPE_I &&
                       (ds || mode_i == PSC_MODE_DS_RETURN)); // [R14]
        end else if (reset_pin_low_i || mode_i == PSC_MODE_INT_RESET) begin // [R1]
            st = PSC_ST_HIZ_IN; // [R7]
            if (pin_func_i == PSC_FUNC_DEBUG) begin
                pull = 1'b1; // [R8]
            end
            if (pin_func_i == PSC_FUNC_GPIO || pin_func_i == PSC_FUNC_NMI ||
                pin_func_i == PSC_FUNC_ANALOG_OUT) begin
                st = PSC_ST_LOCKED;
            end
        end else if (pin_func_i == PSC_FUNC_DEBUG) begin
            st = PSC_ST_HOLD; // [R8]
        end else if (mode_i == PSC_MODE_RUN || mode_i == PSC_MODE_SLEEP) begin
            st = PSC_ST_NORMAL;
        end else if (is_standby(mode_i)) begin
            if (pin_func_i == PSC_FUNC_NMI || pin_func_i == PSC_FUNC_EXT_INT) begin
                st = PSC_ST_HOLD;
            end else if (pin_func_i == PSC_FUNC_ANALOG_OUT) begin
                if (mode_i == PSC_MODE_TIMER) begin
                    st = PSC_ST_HOLD; // [R15]
                end else begin
                    st = (standby_pin_level_bit == PSC_SPL_BEHAVIOUR_A) ? PSC_ST_GPIO_LOW : PSC_ST_HIZ_LOW; // [R16]
                end
            end else begin
                st = (standby_pin_level_bit == PSC_SPL_BEHAVIOUR_A) ? PSC_ST_HOLD : PSC_ST_HIZ_LOW; // [R9]
            end
        end else if (ds) begin
            if (pin_func_i == PSC_FUNC_NMI) begin
                st = PSC_ST_HOLD;
            end else if (pin_type_i == PSC_TYPE_I && pin_func_i != PSC_FUNC_GPIO) begin
                // Wake-capable pins keep wake-up input alive [R12]
                wake = 1'b1;
                st = (standby_pin_level_bit == PSC_SPL_BEHAVIOUR_A) ? PSC_ST_HOLD : PSC_ST_HIZ_LOW;
            end else begin
                st = (standby_pin_level_bit == PSC_SPL_BEHAVIOUR_A) ? PSC_ST_GPIO_LOW : PSC_ST_HIZ_LOW; // [R10] [R11]
            end
        end else begin
            // Return from deep standby [R17]
            st = (pin_type_i == PSC_TYPE_I && pin_func_i == PSC_FUNC_GPIO) ?
                 PSC_ST_HOLD : PSC_ST_GPIO;
        end
    end

    // Port or peripheral output is captured whenever the pin is not in hold
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            held_out <= PSC_HOLD_RESET;
            held_oe <= PSC_HOLD_RESET;
        end else if (st != PSC_ST_HOLD) begin
            held_out <= (pin_func_i == PSC_FUNC_GPIO) ? port_out_i : periph_out_i;
            held_oe <= (pin_func_i == PSC_FUNC_GPIO) ? port_oe_i : periph_oe_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pad_out_o <= 1'b0;
            pad_oe_o <= 1'b0;
            pull_up_o <= 1'b0;
            core_in_o <= PSC_FORCED_LOW;
            analog_en_o <= 1'b0;
            wake_up_input_o <= 1'b0;
            gpio_forced_o <= 1'b0;
            config_locked_o <= 1'b0;
        end else begin
            pull_up_o <= pull;
            analog_en_o <= analog;
            wake_up_input_o <= wake;
            gpio_forced_o <= (st == PSC_ST_GPIO) || (st == PSC_ST_GPIO_LOW);
            config_locked_o <= (st == PSC_ST_LOCKED);
            unique case (st)
                PSC_ST_HIZ_IN: begin
                    pad_out_o <= 1'b0;
                    pad_oe_o <= 1'b0; // [R4]
                    core_in_o <= pad_in_i;
                end
                PSC_ST_HIZ_LOW, PSC_ST_LOCKED: begin
                    pad_out_o <= 1'b0;
                    pad_oe_o <= 1'b0; // [R4]
                    core_in_o <= wake ? pad_in_i : PSC_FORCED_LOW; // [R3]
                end
                PSC_ST_HOLD: begin
                    // A running peripheral keeps driving; a port keeps its latch [R5]
                    if (pin_func_i != PSC_FUNC_GPIO && periph_running_i) begin
                        pad_out_o <= periph_out_i;
                        pad_oe_o <= periph_oe_i;
                    end else begin
                        pad_out_o <= held_out;
                        pad_oe_o <= held_oe;
                    end
                    core_in_o <= pad_in_i;
                end
                PSC_ST_GPIO_LOW: begin
                    pad_out_o <= port_out_i;
                    pad_oe_o <= port_oe_i;
                    core_in_o <= PSC_FORCED_LOW; // [R3]
                end
                PSC_ST_GPIO: begin
                    pad_out_o <= port_out_i;
                    pad_oe_o <= port_oe_i;
                    core_in_o <= pad_in_i;
                end
                PSC_ST_NORMAL: begin
                    pad_out_o <= (pin_func_i == PSC_FUNC_GPIO) ? port_out_i : periph_out_i;
                    pad_oe_o <= (pin_func_i == PSC_FUNC_GPIO) ? port_oe_i : periph_oe_i;
                    core_in_o <= pad_in_i;
                end
            endcase
        end
    end
endmodule // psc_pin_cell

//--- src/psc_pkg.sv
package psc_pkg;
    // Power / reset state of the device as seen by the pin logic
    typedef enum logic [3:0] {
        PSC_MODE_POR,
        PSC_MODE_INT_RESET,
        PSC_MODE_RUN,
        PSC_MODE_SLEEP,
        PSC_MODE_TIMER,
        PSC_MODE_RTC,
        PSC_MODE_STOP,
        PSC_MODE_DS_RTC,
        PSC_MODE_DS_STOP,
        PSC_MODE_DS_RETURN
    } psc_mode_t;

    // Pin status type of each pin
    typedef enum logic [2:0] {
        PSC_TYPE_I,
        PSC_TYPE_J,
        PSC_TYPE_K,
        PSC_TYPE_L,
        PSC_TYPE_M,
        PSC_TYPE_N
    } psc_type_t;

    // Selected function group of each pin
    typedef enum logic [2:0] {
        PSC_FUNC_GPIO,
        PSC_FUNC_RESOURCE,
        PSC_FUNC_ANALOG_IN,
        PSC_FUNC_ANALOG_OUT,
        PSC_FUNC_EXT_INT,
        PSC_FUNC_NMI,
        PSC_FUNC_DEBUG
    } psc_func_t;

    localparam int PSC_MODE_W = 4;
    localparam int PSC_TYPE_W = 3;
    localparam int PSC_FUNC_W = 3;
    localparam int PSC_NUM_PINS = 8;
    localparam logic PSC_SPL_BEHAVIOUR_A = 1'h0;
    localparam logic PSC_SPL_BEHAVIOUR_B = 1'h1;
    localparam logic PSC_HOLD_RESET = 1'h0;
    localparam logic PSC_FORCED_LOW = 1'h0;
endpackage

//--- src/psc_pin_state_ctrl.sv
`timescale 1ns/1ps
// Function
// [R1] Reset pin low means reset-input state
// [R2] Standby pin-level bit picks standby behaviour set
// [R3] Unusable input forces internal input low
// [R4] High-impedance state disables output driver
// [R5] Hold state follows running peripheral or port
// [R6] Unstable supply: resources high-Z, rest unconfigurable
// [R7] Resets: resource pins high-Z, input enabled
// [R8] Debug pins pull-up in reset, then hold
// [R9] Standby digital pins hold, or high-Z low
// [R10] Deep standby switches pins to GPIO
// [R11] Deep standby: GPIO low, or high-Z low
// [R12] Wake-up pins keep wake input in deep standby
// [R13] First analog type disabled in deep standby
// [R14] Other analog types always keep analog input (code turns analog_en_o off in power-on)
// [R15] Analog output holds in timer mode
// [R16] Analog output RTC/stop: GPIO low or high-Z
// [R17] Deep standby return leaves pins as GPIO
// [R18] Oscillator stops in stop and deep stop
// [R19] Pin state decode is combinational on inputs
module psc_pin_state_ctrl
    import psc_pkg::*;
#(
    parameter int NUM_PINS = PSC_NUM_PINS
) (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic external_reset_pin_n_i,
    input wire psc_mode_t mode_i,
    input wire logic standby_pin_level_bit_i,
    input wire logic [NUM_PINS*PSC_TYPE_W-1:0] pin_type_i,
    input wire logic [NUM_PINS*PSC_FUNC_W-1:0] pin_func_i,
    input wire logic [NUM_PINS-1:0] periph_running_i,
    input wire logic [NUM_PINS-1:0] periph_out_i,
    input wire logic [NUM_PINS-1:0] periph_oe_i,
    input wire logic [NUM_PINS-1:0] port_out_i,
    input wire logic [NUM_PINS-1:0] port_oe_i,
    input wire logic [NUM_PINS-1:0] pad_in_i,
    output logic [NUM_PINS-1:0] pad_out_o,
    output logic [NUM_PINS-1:0] pad_oe_o,
    output logic [NUM_PINS-1:0] pull_up_o,
    output logic [NUM_PINS-1:0] core_in_o,
    output logic [NUM_PINS-1:0] analog_en_o,
    output logic [NUM_PINS-1:0] wake_up_input_o,
    output logic [NUM_PINS-1:0] gpio_forced_o,
    output logic [NUM_PINS-1:0] config_locked_o,
    output logic osc_enable_o
);
    logic reset_pin_low;

    assign reset_pin_low = !external_reset_pin_n_i; // [R1]

    // Registered so the oscillator gate never glitches on mode decode
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            osc_enable_o <= 1'b1;
        end else begin
            osc_enable_o <= !(mode_i == PSC_MODE_STOP || mode_i == PSC_MODE_DS_STOP); // [R18]
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
            psc_pin_cell u_cell (
                .core_clk_i(core_clk_i),
                .resetn_i(resetn_i),
                .mode_i(mode_i),
                .reset_pin_low_i(reset_pin_low),
                .standby_pin_level_bit_i(standby_pin_level_bit_i),
                .pin_type_i(psc_type_t'(pin_type_i[gi*PSC_TYPE_W +: PSC_TYPE_W])),
                .pin_func_i(psc_func_t'(pin_func_i[gi*PSC_FUNC_W +: PSC_FUNC_W])),
                .periph_running_i(periph_running_i[gi]),
                .periph_out_i(periph_out_i[gi]),
                .periph_oe_i(periph_oe_i[gi]),
                .port_out_i(port_out_i[gi]),
                .port_oe_i(port_oe_i[gi]),
                .pad_in_i(pad_in_i[gi]),
                .pad_out_o(pad_out_o[gi]),
                .pad_oe_o(pad_oe_o[gi]),
                .pull_up_o(pull_up_o[gi]),
                .core_in_o(core_in_o[gi]),
                .analog_en_o(analog_en_o[gi]),
                .wake_up_input_o(wake_up_input_o[gi]),
                .gpio_forced_o(gpio_forced_o[gi]),
                .config_locked_o(config_locked_o[gi])
            );
        end
    endgenerate
endmodule // psc_pin_state_ctrl

//--- test/psc_pin_state_checker.sv
`timescale 1ns/1ps
module psc_pin_state_checker
    import psc_pkg::*;
#(
    parameter int NUM_PINS = PSC_NUM_PINS
) (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic external_reset_pin_n_i,
    input wire psc_mode_t mode_i,
    input wire logic standby_pin_level_bit_i,
    input wire logic [NUM_PINS*PSC_TYPE_W-1:0] pin_type_i,
    input wire logic [NUM_PINS*PSC_FUNC_W-1:0] pin_func_i,
    input wire logic [NUM_PINS-1:0] periph_running_i,
    input wire logic [NUM_PINS-1:0] periph_out_i,
    input wire logic [NUM_PINS-1:0] pad_out_o,
    input wire logic [NUM_PINS-1:0] pad_oe_o,
    input wire logic [NUM_PINS-1:0] pull_up_o,
    input wire logic [NUM_PINS-1:0] core_in_o,
    input wire logic [NUM_PINS-1:0] analog_en_o,
    input wire logic [NUM_PINS-1:0] wake_up_input_o,
    input wire logic [NUM_PINS-1:0] gpio_forced_o,
    input wire logic osc_enable_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    sequence in_reset_s;
        mode_i != PSC_MODE_POR && (!external_reset_pin_n_i || mode_i == PSC_MODE_INT_RESET);
    endsequence
    sequence stby_s;
        external_reset_pin_n_i && mode_i inside {PSC_MODE_TIMER, PSC_MODE_RTC, PSC_MODE_STOP};
    endsequence
    sequence deep_s;
        external_reset_pin_n_i && mode_i inside {PSC_MODE_DS_RTC, PSC_MODE_DS_STOP};
    endsequence
    osc_stop_a: assert property (
        mode_i inside {PSC_MODE_STOP, PSC_MODE_DS_STOP} |=> !osc_enable_o)
        else $error("oscillator still enabled");
    for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
        wire logic [2:0] f = pin_func_i[3*p+:3];
        wire logic [2:0] t = pin_type_i[3*p+:3];
        por_hiz_a: assert property (
            mode_i == PSC_MODE_POR |=> !pad_oe_o[p]) else $error("driving in power-on");
        reset_hiz_a: assert property (
            in_reset_s ##0 f == PSC_FUNC_RESOURCE |=> !pad_oe_o[p])
            else $error("resource driving in reset");
        debug_pull_a: assert property (
            in_reset_s ##0 f == PSC_FUNC_DEBUG |=> pull_up_o[p] && !pad_oe_o[p])
            else $error("debug pin without pull-up");
        stby_hold_a: assert property (
            stby_s ##0 (!standby_pin_level_bit_i && f == PSC_FUNC_RESOURCE && periph_running_i[p])
            |=> pad_out_o[p] == $past(periph_out_i[p])) else $error("held pin not following");
        stby_hiz_a: assert property (
            stby_s ##0 (standby_pin_level_bit_i && f == PSC_FUNC_RESOURCE)
            |=> !pad_oe_o[p] && !core_in_o[p]) else $error("standby pin not high-Z low");
        deep_gpio_a: assert property (
            deep_s ##0 (!standby_pin_level_bit_i && f == PSC_FUNC_RESOURCE && t != PSC_TYPE_I)
            |=> gpio_forced_o[p] && !core_in_o[p]) else $error("deep standby not GPIO");
        wake_keep_a: assert property (
            deep_s ##0 (standby_pin_level_bit_i && f == PSC_FUNC_RESOURCE && t == PSC_TYPE_I)
            |=> wake_up_input_o[p] && !pad_oe_o[p]) else $error("wake input lost");
        analog_keep_a: assert property (
            mode_i != PSC_MODE_POR && f == PSC_FUNC_ANALOG_IN && t != PSC_TYPE_I
            |=> analog_en_o[p] && !core_in_o[p]) else $error("analog input not kept");
        analog_off_a: assert property (
            t == PSC_TYPE_I && f == PSC_FUNC_ANALOG_IN
            && mode_i inside {PSC_MODE_DS_RTC, PSC_MODE_DS_STOP, PSC_MODE_DS_RETURN}
            |=> !analog_en_o[p]) else $error("analog input left on");
        aout_split_a: assert property (
            stby_s ##0 (mode_i != PSC_MODE_TIMER && t == PSC_TYPE_L && f == PSC_FUNC_ANALOG_OUT)
            |=> !core_in_o[p] && ($past(standby_pin_level_bit_i) ? !pad_oe_o[p] : gpio_forced_o[p]))
            else $error("analog output state wrong");
    end
endmodule // psc_pin_state_checker

//--- test/psc_board_model.sv
`timescale 1ns/1ps
module psc_board_model #(
    parameter int NUM_PINS = 8
) (
    input wire logic core_clk_i,
    input wire logic [NUM_PINS-1:0] pad_out_i,
    input wire logic [NUM_PINS-1:0] pad_oe_i,
    input wire logic [NUM_PINS-1:0] pull_up_i,
    output logic [NUM_PINS-1:0] pad_level_o
);
    logic [NUM_PINS-1:0] float_q = '0;
    // Undriven pads wander every cycle so a missing forced-low input shows up
    always_ff @(posedge core_clk_i) begin
        float_q <= ~float_q;
    end
    always_comb begin
        for (int p = 0; p < NUM_PINS; p++) begin
            pad_level_o[p] = pad_oe_i[p] ? pad_out_i[p] : (pull_up_i[p] ? 1'h1 : float_q[p]);
        end
    end
endmodule // psc_board_model

//--- test/test_psc_pin_state_ctrl.sv
`timescale 1ns/1ps
module test_psc_pin_state_ctrl;
    import psc_pkg::*;
    localparam int NP = 6;
    typedef struct packed {
        psc_mode_t m;
        logic s, e;
        logic [5:0] oe, om, lo, an, wk, gp;
        logic osc;
    } psc_case_t;
    // Pins 0..5: K resource, J debug, I analog in, I resource, N analog in, L analog out
    localparam psc_case_t CASES [10] = '{
        '{PSC_MODE_INT_RESET, 1'h0, 1'h1, 6'h00, 6'h1F, 6'h14, 6'h14, 6'h00, 6'h00, 1'h1},
        '{PSC_MODE_RUN, 1'h0, 1'h0, 6'h00, 6'h1F, 6'h14, 6'h14, 6'h00, 6'h00, 1'h1},
        '{PSC_MODE_RUN, 1'h0, 1'h1, 6'h0B, 6'h1F, 6'h14, 6'h14, 6'h00, 6'h00, 1'h1},
        '{PSC_MODE_TIMER, 1'h0, 1'h1, 6'h0B, 6'h1F, 6'h14, 6'h14, 6'h00, 6'h00, 1'h1},
        '{PSC_MODE_TIMER, 1'h1, 1'h1, 6'h02, 6'h1F, 6'h1D, 6'h14, 6'h00, 6'h00, 1'h1},
        '{PSC_MODE_STOP, 1'h0, 1'h1, 6'h0B, 6'h1F, 6'h34, 6'h14, 6'h00, 6'h20, 1'h0},
        '{PSC_MODE_RTC, 1'h1, 1'h1, 6'h02, 6'h3F, 6'h3D, 6'h14, 6'h00, 6'h00, 1'h1},
        '{PSC_MODE_DS_STOP, 1'h0, 1'h1, 6'h02, 6'h37, 6'h35, 6'h10, 6'h08, 6'h21, 1'h0},
        '{PSC_MODE_DS_RTC, 1'h1, 1'h1, 6'h02, 6'h3F, 6'h35, 6'h10, 6'h08, 6'h00, 1'h1},
        '{PSC_MODE_DS_RETURN, 1'h0, 1'h1, 6'h02, 6'h3F, 6'h14, 6'h10, 6'h00, 6'h29, 1'h1}};
    logic clk = 1'h0;
    logic rstn = 1'h0;
    logic ext_n = 1'h1;
    psc_mode_t mode = PSC_MODE_POR;
    logic standby_pin_level_bit = 1'h0;
    logic [NP*3-1:0] ptype = {PSC_TYPE_L, PSC_TYPE_N, PSC_TYPE_I, PSC_TYPE_I, PSC_TYPE_J, PSC_TYPE_K};
    logic [NP*3-1:0] pfunc = {PSC_FUNC_ANALOG_OUT, PSC_FUNC_ANALOG_IN, PSC_FUNC_RESOURCE,
        PSC_FUNC_ANALOG_IN, PSC_FUNC_DEBUG, PSC_FUNC_RESOURCE};
    logic [NP-1:0] prun = 6'h3F;
    logic [NP-1:0] pout = 6'h2D;
    logic [NP-1:0] poe = 6'h3F;
    logic [NP-1:0] qout = 6'h00;
    logic [NP-1:0] qoe = 6'h00;
    logic [NP-1:0] pad, d_out, d_oe, d_pu, d_in, d_an, d_wk, d_gp, d_lk;
    logic d_osc;
    int num_errors = 0;
    int num_checks = 0;
    psc_pin_state_ctrl #(.NUM_PINS(NP)) dut (.core_clk_i(clk), .resetn_i(rstn),
        .external_reset_pin_n_i(ext_n), .mode_i(mode), .standby_pin_level_bit_i(standby_pin_level_bit),
        .pin_type_i(ptype), .pin_func_i(pfunc), .periph_running_i(prun),
        .periph_out_i(pout), .periph_oe_i(poe), .port_out_i(qout), .port_oe_i(qoe),
        .pad_in_i(pad), .pad_out_o(d_out), .pad_oe_o(d_oe), .pull_up_o(d_pu),
        .core_in_o(d_in), .analog_en_o(d_an), .wake_up_input_o(d_wk),
        .gpio_forced_o(d_gp), .config_locked_o(d_lk), .osc_enable_o(d_osc));
    psc_board_model #(.NUM_PINS(NP)) board (.core_clk_i(clk), .pad_out_i(d_out),
        .pad_oe_i(d_oe), .pull_up_i(d_pu), .pad_level_o(pad));
    initial begin
        forever #12.5 clk = ~clk;
    end
    task automatic check(input logic [NP-1:0] seen, input logic [NP-1:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Outputs are registered, so look one edge after the inputs land
    task automatic step(input psc_mode_t m, input logic s, input logic e);
        @(posedge clk);
        mode <= m;
        standby_pin_level_bit <= s;
        ext_n <= e;
        @(posedge clk);
        #1;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rstn <= 1'h1;
        step(PSC_MODE_POR, 1'h0, 1'h1);
        check(d_oe & 6'h1F, 6'h00);
        check(d_lk, 6'h20);
        for (int i = 0; i < 10; i++) begin
            step(CASES[i].m, CASES[i].s, CASES[i].e);
            check(d_oe & CASES[i].om, CASES[i].oe);
            check(d_in & CASES[i].lo, 6'h00);
            check(d_an & 6'h14, CASES[i].an);
            check(d_wk & 6'h08, CASES[i].wk);
            check(d_gp, CASES[i].gp);
            check({5'h00, d_osc}, {5'h00, CASES[i].osc});
            if (i < 2) check(d_pu & 6'h02, 6'h02);
            check(d_lk, (i < 2) ? 6'h20 : 6'h00);
        end
        conclude();
    end
    initial begin
        #50000;
        num_errors++;
        conclude();
    end
endmodule // test_psc_pin_state_ctrl
bind psc_pin_state_ctrl psc_pin_state_checker #(.NUM_PINS(NUM_PINS)) chk (.*);
